/* include/lcbusy_consts.svh */
/*
  Constants for the link concentrator: link count, buffer sizes, time-out, codes.
  Assumes inclusion by bare name from package and design files.
*/
`ifndef LCBUSY_CONSTS_SVH
`define LCBUSY_CONSTS_SVH
`define LC_NUM_LINKS        30
`define LC_WORD_BITS        32
`define LC_LINK_BUF_BITS    524288
`define LC_LINK_BUF_WORDS   (`LC_LINK_BUF_BITS / `LC_WORD_BITS)
`define LC_MAX_EVENT_BITS   409600
`define LC_MAX_EVENTS       64
`define LC_LINK_RATE_MBPS   2000
`define LC_UPLINK_RATE_MBPS 10000
`define LC_CLOCK_MHZ        200
`define LC_TIMEOUT_US       100
`define LC_TIMEOUT_CYCLES   (`LC_TIMEOUT_US * `LC_CLOCK_MHZ)
`define LC_KIND_TRACKLET    2'h0
`define LC_KIND_ZS_RAW      2'h1
`define LC_KIND_PARTIAL     2'h2
`define LC_KIND_NZS_RAW     2'h3
`endif

/* include/lcbusy_pkg.sv */
/*
  Types shared by the link concentrator and its output skid buffer.
  Assumes lcbusy_consts.svh on the include path.
*/
`include "lcbusy_consts.svh"
package lcbusy_pkg;
  typedef logic [1:0] lcbusy_kind_type;

  // One word on the uplink; marks carry event framing
  typedef struct packed {
    logic [4:0]                 link;
    logic                       end_of_event;
    logic                       timed_out;
    lcbusy_kind_type            kind;
    logic [`LC_WORD_BITS-1:0]   data;
  } lcbusy_word_type;

  // Trigger message from the trigger channel
  typedef struct packed {
    logic            valid;
    logic            earliest;
    logic            reject;
    lcbusy_kind_type kind;
  } lcbusy_trig_type;

  typedef enum logic [2:0] {
    LCBUSY_IDLE    = 3'h1,
    LCBUSY_COLLECT = 3'h2,
    LCBUSY_CLOSE   = 3'h4
  } lcbusy_state_type;
endpackage : lcbusy_pkg

/* hw/lcbusy_skid.sv */
/*
  Two-entry buffer with valid/ready on both sides.
  Assumes one clock and synchronous active-low reset.
*/
`timescale 1ns/100ps
module lcbusy_skid
  import lcbusy_pkg::*;
(
  input  wire logic            i_clock,
  input  wire logic            i_reset_n,
  input  wire logic            i_valid,
  input  wire lcbusy_word_type i_word,
  output logic                 o_ready,
  output logic                 o_valid,
  output lcbusy_word_type      o_word,
  input  wire logic            i_ready
);
  lcbusy_word_type  out_word_ff, nxt_out_word, hold_word_ff, nxt_hold_word;
  logic             out_valid_ff, nxt_out_valid, hold_valid_ff, nxt_hold_valid;

  // Second slot catches the word in flight when the sink stalls
  always_comb begin
    nxt_out_valid  = out_valid_ff;
    nxt_out_word   = out_word_ff;
    nxt_hold_valid = hold_valid_ff;
    nxt_hold_word  = hold_word_ff;
    if (!out_valid_ff || i_ready) begin
      if (hold_valid_ff) begin
        nxt_out_valid  = 1'b1;
        nxt_out_word   = hold_word_ff;
        nxt_hold_valid = 1'b0;
      end else begin
        nxt_out_valid  = i_valid;
        nxt_out_word   = i_valid ? i_word : out_word_ff;
      end
    end else if (i_valid && !hold_valid_ff) begin
      nxt_hold_valid = 1'b1;
      nxt_hold_word  = i_word;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      out_valid_ff  <= 1'b0;
      hold_valid_ff <= 1'b0;
      out_word_ff   <= '0;
      hold_word_ff  <= '0;
    end else begin
      out_valid_ff  <= nxt_out_valid;
      hold_valid_ff <= nxt_hold_valid;
      out_word_ff   <= nxt_out_word;
      hold_word_ff  <= nxt_hold_word;
    end
  end

  // Ready and outputs come straight from registers
  assign o_ready = !hold_valid_ff;
  assign o_valid = out_valid_ff;
  assign o_word  = out_word_ff;
endmodule : lcbusy_skid

/* hw/lcbusy_concentrator.sv */
/*
  Link concentrator: per-link multi-event buffers, uplink merge, busy generation.
  Assumes link words synchronous to i_clock and a trigger message stream.
*/
// What this block does
// - Thirty input links are accepted, each nominally at 2 Gb/s net.
// - All event data leaves on one uplink word stream nominally at 10 Gb/s.
// - Four event kinds are carried: tracklet, zero-suppressed raw, partial, non-suppressed.
// - Each link has its own buffer holding several queued complete events.
// - Link words are pushed without handshake and are dropped while the buffer is full.
// - Each buffer absorbs one maximum event of 400 kb on all links at once.
// - Buffer space is shared per event, so 512 kb holds up to 64 small events.
// - A rejecting later level within 4 us may abort front-end processing.
// - Only earliest-level trigger messages are used, for busy and for the event kind; reject is ignored.
// - Busy rises when an earliest-level trigger arrives in the LCBUSY_IDLE state.
// - Busy falls once every link has sent its end marker or the time-out expires.
// - Busy is also raised whenever any input buffer is full.
`timescale 1ns/100ps
`include "lcbusy_consts.svh"
module lcbusy_concentrator
  import lcbusy_pkg::*;
#(
  parameter int NUM_LINKS   = `LC_NUM_LINKS,
  parameter int BUF_WORDS   = `LC_LINK_BUF_WORDS,
  parameter int MAX_EVENTS  = `LC_MAX_EVENTS,
  parameter int TIMEOUT_CYC = `LC_TIMEOUT_CYCLES
)(
  input  wire logic                                i_clock,
  input  wire logic                                i_reset_n,
  input  wire logic [NUM_LINKS-1:0]                i_link_valid,
  input  wire logic [NUM_LINKS-1:0][`LC_WORD_BITS-1:0] i_link_data,
  input  wire logic [NUM_LINKS-1:0]                i_link_end,
  input  wire lcbusy_trig_type                     i_trig,
  input  wire logic [23:0]                         i_timeout_cycles,
  input  wire logic                                i_uplink_ready,
  output logic                                     o_uplink_valid,
  output lcbusy_word_type                          o_uplink_word,
  output logic                                     o_busy,
  output logic                                     o_timed_out,
  output logic [NUM_LINKS-1:0]                     o_overflow
);
  localparam int AW = $clog2(BUF_WORDS);
  localparam int EW = $clog2(MAX_EVENTS + 1);
  localparam int LW = $clog2(NUM_LINKS);

  // Per-link buffer storage and pointers
  logic [AW:0]           wr_ptr_ff  [NUM_LINKS];
  logic [AW:0]           rd_ptr_ff  [NUM_LINKS];
  logic [EW-1:0]         events_ff  [NUM_LINKS];
  logic [NUM_LINKS-1:0]  full, has_event, take, ended_ff, nxt_ended;
  logic [NUM_LINKS-1:0]  ovf_ff, nxt_ovf;

  lcbusy_state_type      state_ff, nxt_state;
  logic [23:0]           timer_ff, nxt_timer;
  lcbusy_kind_type       kind_ff, nxt_kind;
  logic                  tmo_ff, nxt_tmo, busy_ff, nxt_busy;
  logic                  tmo_flag_ff, nxt_tmo_flag;
  logic [LW-1:0]         sel_ff, nxt_sel;
  logic                  skid_ready, out_valid;
  lcbusy_word_type       out_word;
  logic                  rd_word_end;
  logic [`LC_WORD_BITS-1:0] rd_word_data;
  logic [`LC_WORD_BITS:0]   link_head [NUM_LINKS];

  // Word memories with end-marker bit; each link owns one
  generate
    for (genvar g = 0; g < NUM_LINKS; g++) begin : g_link
      logic [`LC_WORD_BITS:0] mem [BUF_WORDS];
      logic [AW:0]            nxt_wr, nxt_rd;
      logic [EW-1:0]          nxt_ev;
      logic                   wr_en, rd_en, ev_in, ev_out;

      // Event cap also counts as full, so the event counter never wraps
      assign full[g]      = ((wr_ptr_ff[g] - rd_ptr_ff[g]) == (AW+1)'(BUF_WORDS)) ||
                            (events_ff[g] == EW'(MAX_EVENTS));
      assign has_event[g] = events_ff[g] != '0;
      assign link_head[g] = mem[rd_ptr_ff[g][AW-1:0]];

      always_comb begin
        wr_en  = i_link_valid[g] && !full[g];
        rd_en  = take[g];
        ev_in  = wr_en && i_link_end[g];
        ev_out = rd_en && link_head[g][`LC_WORD_BITS];
        nxt_wr = wr_en ? (AW+1)'(wr_ptr_ff[g] + 1'b1) : wr_ptr_ff[g];
        nxt_rd = rd_en ? (AW+1)'(rd_ptr_ff[g] + 1'b1) : rd_ptr_ff[g];
        nxt_ev = EW'(events_ff[g] + {{(EW-1){1'b0}}, ev_in} - {{(EW-1){1'b0}}, ev_out});
      end

      always_ff @(posedge i_clock) begin
        if (wr_en) begin
          mem[wr_ptr_ff[g][AW-1:0]] <= {i_link_end[g], i_link_data[g]};
        end
      end

      always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
          wr_ptr_ff[g] <= '0;
          rd_ptr_ff[g] <= '0;
          events_ff[g] <= '0;
        end else begin
          wr_ptr_ff[g] <= nxt_wr;
          rd_ptr_ff[g] <= nxt_rd;
          events_ff[g] <= nxt_ev;
        end
      end
    end
  endgenerate

  // Uplink merge: drain one whole event from the selected link, then rotate
  always_comb begin
    take         = '0;
    nxt_sel      = sel_ff;
    rd_word_data = '0;
    rd_word_end  = 1'b0;
    for (int i = 0; i < NUM_LINKS; i++) begin
      if (LW'(i) == sel_ff) begin
        rd_word_data = g_link_rd_data(i);
        rd_word_end  = g_link_rd_end(i);
      end
    end
    out_valid = 1'b0;
    if (has_event[sel_ff] && skid_ready) begin
      take[sel_ff] = 1'b1;
      out_valid    = 1'b1;
      if (rd_word_end) begin
        nxt_sel = (sel_ff == LW'(NUM_LINKS-1)) ? '0 : LW'(sel_ff + 1'b1);
      end
    end else if (!has_event[sel_ff]) begin
      // Skip links with no complete event, so a slow link blocks nobody
      nxt_sel = (sel_ff == LW'(NUM_LINKS-1)) ? '0 : LW'(sel_ff + 1'b1);
    end
    out_word.link         = 5'(sel_ff);
    out_word.end_of_event = rd_word_end;
    out_word.timed_out    = rd_word_end && tmo_flag_ff;
    out_word.kind         = kind_ff;
    out_word.data         = rd_word_data;
  end

  function automatic logic [`LC_WORD_BITS-1:0] g_link_rd_data(input int idx);
    g_link_rd_data = '0;
    for (int k = 0; k < NUM_LINKS; k++) begin
      if (k == idx) begin
        g_link_rd_data = link_head[k][`LC_WORD_BITS-1:0];
      end
    end
  endfunction : g_link_rd_data

  function automatic logic g_link_rd_end(input int idx);
    g_link_rd_end = 1'b0;
    for (int k = 0; k < NUM_LINKS; k++) begin
      if (k == idx) begin
        g_link_rd_end = link_head[k][`LC_WORD_BITS];
      end
    end
  endfunction : g_link_rd_end

  // Busy sequencer driven by trigger messages
  always_comb begin
    nxt_state    = state_ff;
    nxt_timer    = timer_ff;
    nxt_ended    = ended_ff | (i_link_valid & i_link_end);
    nxt_kind     = kind_ff;
    nxt_tmo      = tmo_ff;
    nxt_tmo_flag = tmo_flag_ff;
    nxt_ovf      = ovf_ff | (i_link_valid & full);   // Word lost only if buffer overfilled
    case (state_ff)
      LCBUSY_IDLE: begin
        nxt_ended = '0;
        // Reject levels only stop the front end; busy waits for markers
        if (i_trig.valid && i_trig.earliest) begin
          nxt_state = LCBUSY_COLLECT;
          nxt_timer = '0;
          nxt_kind  = i_trig.kind;
          nxt_tmo   = 1'b0;
        end
      end
      LCBUSY_COLLECT: begin
        nxt_timer = 24'(timer_ff + 1'b1);
        if (&nxt_ended) begin
          nxt_state    = LCBUSY_CLOSE;
          nxt_tmo_flag = 1'b0;
        end else if (timer_ff >= i_timeout_cycles - 24'h1) begin
          nxt_state    = LCBUSY_CLOSE;
          nxt_tmo      = 1'b1;
          nxt_tmo_flag = 1'b1;
        end
      end
      LCBUSY_CLOSE: begin
        nxt_state = LCBUSY_IDLE;
      end
      default: begin
        nxt_state = LCBUSY_IDLE;
      end
    endcase
    nxt_busy = (nxt_state == LCBUSY_COLLECT) || (|full);
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      state_ff    <= LCBUSY_IDLE;
      timer_ff    <= 24'h0;
      ended_ff    <= '0;
      kind_ff     <= `LC_KIND_TRACKLET;
      tmo_ff      <= 1'b0;
      tmo_flag_ff <= 1'b0;
      busy_ff     <= 1'b0;
      ovf_ff      <= '0;
      sel_ff      <= '0;
    end else begin
      state_ff    <= nxt_state;
      timer_ff    <= nxt_timer;
      ended_ff    <= nxt_ended;
      kind_ff     <= nxt_kind;
      tmo_ff      <= nxt_tmo;
      tmo_flag_ff <= nxt_tmo_flag;
      busy_ff     <= nxt_busy;
      ovf_ff      <= nxt_ovf;
      sel_ff      <= nxt_sel;
    end
  end

  // Output buffer keeps uplink stalls from dropping words
  logic            up_valid;
  lcbusy_word_type up_word;
  lcbusy_skid u_skid (
    .i_clock   (i_clock),
    .i_reset_n (i_reset_n),
    .i_valid   (out_valid),
    .i_word    (out_word),
    .o_ready   (skid_ready),
    .o_valid   (up_valid),
    .o_word    (up_word),
    .i_ready   (i_uplink_ready)
  );

  assign o_uplink_valid = up_valid;
  assign o_uplink_word  = up_word;
  assign o_busy         = busy_ff;
  assign o_timed_out    = tmo_ff;
  assign o_overflow     = ovf_ff;
endmodule : lcbusy_concentrator

/* sim/lcbusy_props.sv */
/* Port checker for the link concentrator.
   Assumes binding onto lcbusy_concentrator, one clock, sync low reset. */
`timescale 1ns/100ps
module lcbusy_props
  import lcbusy_pkg::*;
#(
  parameter int NUM_LINKS = 30
)(
  input wire logic                 i_clock,
  input wire logic                 i_reset_n,
  input wire logic [NUM_LINKS-1:0] i_link_valid,
  input wire logic [NUM_LINKS-1:0] i_link_end,
  input wire lcbusy_trig_type      i_trig,
  input wire logic [23:0]          i_timeout_cycles,
  input wire logic                 i_uplink_ready,
  input wire logic                 o_uplink_valid,
  input wire lcbusy_word_type      o_uplink_word,
  input wire logic                 o_busy,
  input wire logic                 o_timed_out,
  input wire logic [NUM_LINKS-1:0] o_overflow
);
  logic [NUM_LINKS-1:0] seen_ff, nxt_seen;
  logic [24:0]          idle_ff, nxt_idle;

  // Ends and quiet cycles only count while busy
  always_comb begin
    nxt_seen = seen_ff | (i_link_valid & i_link_end);
    nxt_idle = idle_ff + 25'h1;
    if (!o_busy || !i_reset_n) nxt_seen = '0;
    if (!o_busy || !i_reset_n || i_trig.valid || (|i_link_valid)) nxt_idle = 25'h0;
  end

  always_ff @(posedge i_clock) begin
    seen_ff <= nxt_seen;
    idle_ff <= nxt_idle;
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  sequence trig_taken;
    i_trig.valid && i_trig.earliest && !o_busy;
  endsequence
  sequence all_ends_in;
    (&seen_ff) && o_busy;
  endsequence

  AST_BUSY_RISE: assert property (trig_taken |-> ##[1:2] o_busy)
    else $error("busy missing after earliest trigger");
  AST_END_RELEASE: assert property (all_ends_in |-> ##[0:2] !o_busy)
    else $error("busy held after all end markers");
  AST_BUSY_TIMEOUT: assert property (o_busy |-> idle_ff <= {1'b0, i_timeout_cycles} + 25'h4)
    else $error("busy outlived the time-out");
  AST_OVF_STICKY: assert property ((o_overflow & $past(o_overflow)) == $past(o_overflow))
    else $error("overflow flag cleared");
  AST_OVF_BUSY: assert property ($changed(o_overflow) && (|o_overflow) |-> ##[0:1] o_busy)
    else $error("full buffer without busy");
  AST_UP_HOLD: assert property (o_uplink_valid && !i_uplink_ready |=> o_uplink_valid && $stable(o_uplink_word))
    else $error("uplink word changed while stalled");
  AST_TO_FLAG: assert property (o_uplink_valid && o_uplink_word.timed_out |-> o_uplink_word.end_of_event)
    else $error("time-out mark on a non-end word");
  AST_LINK_RANGE: assert property (o_uplink_valid |-> o_uplink_word.link < NUM_LINKS)
    else $error("uplink link index out of range");
  AST_TO_FALL: assert property ($rose(o_timed_out) |-> ##[0:2] !o_busy)
    else $error("time-out flagged but busy held");
endmodule : lcbusy_props

bind lcbusy_concentrator lcbusy_props #(.NUM_LINKS(NUM_LINKS)) u_props (
  .i_clock(i_clock), .i_reset_n(i_reset_n), .i_link_valid(i_link_valid),
  .i_link_end(i_link_end), .i_trig(i_trig), .i_timeout_cycles(i_timeout_cycles),
  .i_uplink_ready(i_uplink_ready), .o_uplink_valid(o_uplink_valid),
  .o_uplink_word(o_uplink_word), .o_busy(o_busy), .o_timed_out(o_timed_out),
  .o_overflow(o_overflow));

/* sim/lcbusy_fe_model.sv */
/* Front-end link model: pushes event words, no handshake.
   Assumes the bench calls send_event; drives after falling edges. */
`timescale 1ns/100ps
`include "lcbusy_consts.svh"
module lcbusy_fe_model #(
  parameter int NUM_LINKS = 30
)(
  input  wire logic                               i_clock,
  output logic [NUM_LINKS-1:0]                    o_link_valid,
  output logic [NUM_LINKS-1:0][`LC_WORD_BITS-1:0] o_link_data,
  output logic [NUM_LINKS-1:0]                    o_link_end
);
  initial begin
    o_link_valid = '0;
    o_link_end   = '0;
    o_link_data  = '0;
  end

  // Idle lines show inverted data; a second idle cycle in a row restores the last word
  task automatic idle();
    @(negedge i_clock);
    o_link_valid <= '0;
    o_link_end   <= '0;
    o_link_data  <= ~o_link_data;
  endtask : idle

  // Never waits on the receiver, so a full buffer loses words
  task automatic send_event(input logic [NUM_LINKS-1:0] mask, input int words, input int gap);
    for (int w = 0; w < words; w++) begin
      @(negedge i_clock);
      o_link_valid <= mask;
      o_link_end   <= (w == words - 1) ? mask : '0;
      for (int l = 0; l < NUM_LINKS; l++) begin
        o_link_data[l] <= {8'(l), 8'(w), 16'hA5C3};
      end
      repeat (gap) idle();
    end
    idle();
  endtask : send_event
endmodule : lcbusy_fe_model

/* sim/lcbusy_concentrator_tb_top.sv */
/* Bench for the link concentrator: busy, time-out, overflow, uplink.
   Assumes lcbusy_fe_model as the link source and the bound checker. */
`timescale 1ns/100ps
`include "lcbusy_consts.svh"
module lcbusy_concentrator_tb_top;
  import lcbusy_pkg::*;
  localparam int NL = `LC_NUM_LINKS;
  logic                             i_clock, i_reset_n, o_uplink_valid, o_busy, o_timed_out;
  logic                             up_ready = 1'b1;
  logic                             kind_on  = 1'b0;
  logic [NL-1:0]                    link_valid, link_end, o_overflow;
  logic [NL-1:0][`LC_WORD_BITS-1:0] link_data;
  logic [23:0]                      to_cycles;
  lcbusy_trig_type                  trig;
  lcbusy_word_type                  up_word;
  lcbusy_kind_type                  exp_kind;
  int                               err_total, compares, n_words, n_ends, stall;

  lcbusy_fe_model #(.NUM_LINKS(NL)) u_fe (.i_clock(i_clock), .o_link_valid(link_valid),
    .o_link_data(link_data), .o_link_end(link_end));
  // Small buffer so a short burst fills it
  lcbusy_concentrator #(.BUF_WORDS(16)) u_dut (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_link_valid(link_valid), .i_link_data(link_data), .i_link_end(link_end), .i_trig(trig),
    .i_timeout_cycles(to_cycles), .i_uplink_ready(up_ready), .o_uplink_valid(o_uplink_valid),
    .o_uplink_word(up_word), .o_busy(o_busy), .o_timed_out(o_timed_out),
    .o_overflow(o_overflow));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  // Sink: 0 prompt, 1 every other cycle, 2 stalled
  always @(negedge i_clock) up_ready <= (stall == 0) || (stall == 1 && !up_ready);

  always @(posedge i_clock) begin
    if (i_reset_n && o_uplink_valid && up_ready) begin
      n_words++;
      if (up_word.end_of_event) n_ends++;
      chk(32'(up_word.data[31:24]), 32'(up_word.link));
      if (kind_on) chk(32'(up_word.kind), 32'(exp_kind));
      if (kind_on) chk(32'(up_word.timed_out), 32'h0);
    end
  end

  task automatic pulse(input logic early, input logic rej, input lcbusy_kind_type k);
    @(negedge i_clock);
    trig <= '{1'b1, early, rej, k};
    @(negedge i_clock);
    trig <= '0;
  endtask : pulse

  task automatic wait_idle(output int c);
    c = 0;
    while (o_busy !== 1'b0 && c < 400) begin
      @(negedge i_clock);
      c++;
    end
  endtask : wait_idle

  task automatic drain(input int n);
    for (int i = 0; i < 300 && n_words < n; i++) @(negedge i_clock);
    chk(n_words, n);
  endtask : drain

  task automatic t_end_markers();
    int c;
    kind_on = 1'b1;
    for (int k = 0; k < 4; k++) begin
      exp_kind = 2'(k);
      n_words  = 0;
      n_ends   = 0;
      stall    = 1;
      pulse(1'b1, 1'b0, 2'(k));
      @(negedge i_clock);
      chk(o_busy, 1);
      u_fe.send_event('1, 3, k);
      wait_idle(c);
      chk(c <= 3, 1);
      chk(o_timed_out, 0);
      stall = 0;
      drain(3 * NL);
      chk(n_ends, NL);
    end
    kind_on = 1'b0;
    $display("end marker test done");
  endtask : t_end_markers

  task automatic t_timeout();
    int c;
    longint t0;
    n_words = 0;
    t0 = $time;
    pulse(1'b1, 1'b0, 2'h0);
    u_fe.send_event({{(NL-1){1'b1}}, 1'b0}, 2, 0);
    pulse(1'b0, 1'b1, 2'h0);
    pulse(1'b1, 1'b0, 2'h0);
    chk(o_busy, 1);
    wait_idle(c);
    c = int'(($time - t0) / 5);
    chk(c >= 50 && c <= 60, 1);
    chk(o_timed_out, 1);
    repeat (3) @(negedge i_clock);
    chk(o_busy, 0);
    drain(2 * (NL - 1));
    $display("time-out test done");
  endtask : t_timeout

  task automatic t_overflow();
    int c;
    stall   = 2;
    n_words = 0;
    // Complete event first, then one that overruns the stalled buffer
    u_fe.send_event(NL'(8), 10, 0);
    u_fe.send_event(NL'(8), 10, 0);
    chk(o_busy, 1);
    chk(o_overflow, 32'(NL'(8)));
    stall = 0;
    wait_idle(c);
    chk(c < 40, 1);
    chk(o_overflow, 32'(NL'(8)));
    drain(10);
    $display("overflow test done");
  endtask : t_overflow

  initial begin
    i_reset_n = 1'b0;
    trig      = '0;
    to_cycles = 24'h32;
    stall     = 0;
    repeat (4) @(negedge i_clock);
    chk(o_busy, 0);
    i_reset_n = 1'b1;
    t_end_markers();
    t_timeout();
    t_overflow();
    print_verdict();
  end

  // Tests need under 2000 cycles
  initial begin
    #20000;
    err_total++;
    print_verdict();
  end
endmodule : lcbusy_concentrator_tb_top
